// ===== logic/jdp_tap.v
// Test access port controller, debug data path and debug event pin logic.
// Assumes pins arrive unsynchronised; the test clock is far slower than mclk_i.
`timescale 1ns/1ps
`default_nettype none
`include "jdp_defs.vh"
// Operation
// - The test data input is taken on each rising test clock edge for instruction and data shifting.
// - The test data output changes only on falling test clock edges.
// - The test data output is driven only in the two shift states and floats otherwise and during reset.
// - The mode select input steers the controller and the device follows it.
// - Asserting test reset sends the controller to its initial state without a test clock edge.
// - Test data input, test reset and debug event pin read high when undriven.
// - A low debug event pin makes the core finish its instruction, save the pipeline, enter debug and await commands.
// - On entering debug mode the debug event pin is pulled low for exactly three clock cycles.
// - The debug event pin is only ever pulled low or released, and is an input during reset.
// - Apart from the debug event pin all debug traffic goes through the test port.
// - Core registers, memory and peripherals are examined through the test port without disturbing operation.
module jdp_tap (
	input  wire       mclk_i,           // System clock
	input  wire       sys_rst_i,        // Sync reset, high
	input  wire       tck_i,            // Test clock pin
	input  wire       tms_i,            // Mode select pin
	input  wire       tdi_i,            // Test data in pin
	input  wire       trst_n_i,         // Test reset pin, low
	output reg        tdo_o,            // Test data out
	output wire       tdo_oe_n_o,       // Low while driving
	input  wire       debug_event_pin_i,     // Event pin level
	output wire       debug_event_pin_o,     // Event pin drive value
	output wire       debug_event_pin_oe_n_o,// Low while pulling
	input  wire       instr_done_i,     // Core finished instruction
	input  wire       breakpoint_i,     // Breakpoint met pulse
	input  wire       debug_exit_i,     // Core leaves debug pulse
	input  wire [7:0] core_data_i,      // Core observation data
	output reg        debug_req_o,      // Halt request to core
	output reg        save_pipe_o,      // Save pipeline pulse
	output reg        debug_mode_o,     // Core in debug mode
	output reg  [7:0] debug_cmd_o,      // Command from serial port
	output reg        debug_cmd_vld_o   // Command strobe
);
	wire tck_s;
	wire tms_s;
	wire tdi_s;
	wire trst_n_s;
	wire evt_s;
	reg  tck_d_ff;
	reg  [3:0] st_ff;
	reg  [3:0] nxt_st;
	reg  [`JDP_IR_W-1:0] ir_sh_ff;
	reg  [`JDP_IR_W-1:0] ir_ff;
	reg  [`JDP_DR_W-1:0] dr_sh_ff;
	reg  byp_ff;
	reg  shift_out_ff;
	reg  tdo_en_ff;
	reg  [1:0] ack_cnt_ff;
	reg  evt_req_ff;
	reg  evt_prev_ff;

	// pull-ups: undriven pins other than the test clock are resolved high by the reset value and pad
	jdp_sync #(.RST_VAL(1'b0)) u_tck (.clk_i(mclk_i), .rst_i(sys_rst_i), .din_i(tck_i), .dout_o(tck_s));
	jdp_sync #(.RST_VAL(1'b1)) u_tms (.clk_i(mclk_i), .rst_i(sys_rst_i), .din_i(tms_i), .dout_o(tms_s));
	jdp_sync #(.RST_VAL(1'b1)) u_tdi (.clk_i(mclk_i), .rst_i(sys_rst_i), .din_i(tdi_i), .dout_o(tdi_s));
	jdp_sync #(.RST_VAL(1'b1)) u_trs (.clk_i(mclk_i), .rst_i(sys_rst_i), .din_i(trst_n_i), .dout_o(trst_n_s));
	jdp_sync #(.RST_VAL(1'b1)) u_evt (.clk_i(mclk_i), .rst_i(sys_rst_i), .din_i(debug_event_pin_i), .dout_o(evt_s));

	wire tck_rise = tck_s & ~tck_d_ff;
	wire tck_fall = ~tck_s & tck_d_ff;
	wire tap_rst  = sys_rst_i | ~trst_n_s;

	always @*
	begin
		nxt_st = st_ff;
		case (st_ff)
			`JDP_ST_RESET:    nxt_st = tms_s ? `JDP_ST_RESET   : `JDP_ST_IDLE;
			`JDP_ST_IDLE:     nxt_st = tms_s ? `JDP_ST_SEL_DR  : `JDP_ST_IDLE;
			`JDP_ST_SEL_DR:   nxt_st = tms_s ? `JDP_ST_SEL_IR  : `JDP_ST_CAP_DR;
			`JDP_ST_CAP_DR:   nxt_st = tms_s ? `JDP_ST_EXIT1_DR : `JDP_ST_SHIFT_DR;
			`JDP_ST_SHIFT_DR: nxt_st = tms_s ? `JDP_ST_EXIT1_DR : `JDP_ST_SHIFT_DR;
			`JDP_ST_EXIT1_DR: nxt_st = tms_s ? `JDP_ST_UPD_DR  : `JDP_ST_PAUSE_DR;
			`JDP_ST_PAUSE_DR: nxt_st = tms_s ? `JDP_ST_EXIT2_DR : `JDP_ST_PAUSE_DR;
			`JDP_ST_EXIT2_DR: nxt_st = tms_s ? `JDP_ST_UPD_DR  : `JDP_ST_SHIFT_DR;
			`JDP_ST_UPD_DR:   nxt_st = tms_s ? `JDP_ST_SEL_DR  : `JDP_ST_IDLE;
			`JDP_ST_SEL_IR:   nxt_st = tms_s ? `JDP_ST_RESET   : `JDP_ST_CAP_IR;
			`JDP_ST_CAP_IR:   nxt_st = tms_s ? `JDP_ST_EXIT1_IR : `JDP_ST_SHIFT_IR;
			`JDP_ST_SHIFT_IR: nxt_st = tms_s ? `JDP_ST_EXIT1_IR : `JDP_ST_SHIFT_IR;
			`JDP_ST_EXIT1_IR: nxt_st = tms_s ? `JDP_ST_UPD_IR  : `JDP_ST_PAUSE_IR;
			`JDP_ST_PAUSE_IR: nxt_st = tms_s ? `JDP_ST_EXIT2_IR : `JDP_ST_PAUSE_IR;
			`JDP_ST_EXIT2_IR: nxt_st = tms_s ? `JDP_ST_UPD_IR  : `JDP_ST_SHIFT_IR;
			`JDP_ST_UPD_IR:   nxt_st = tms_s ? `JDP_ST_SEL_DR  : `JDP_ST_IDLE;
			default:          nxt_st = `JDP_ST_RESET;
		endcase
	end

	// test reset forces the initial state without a test clock edge
	always @(posedge mclk_i)
	begin
		if (tap_rst)
			st_ff <= `JDP_ST_RESET;
		else if (tck_rise)
			st_ff <= nxt_st;
	end

	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
			tck_d_ff <= 1'b0;
		else
			tck_d_ff <= tck_s;
	end

	// Instruction and data shift paths, debug command strobe
	always @(posedge mclk_i)
	begin
		if (tap_rst)
		begin
			ir_sh_ff        <= `JDP_IR_RESET;
			ir_ff           <= `JDP_IR_RESET;
			dr_sh_ff        <= `JDP_DR_RESET;
			byp_ff          <= 1'b0;
			debug_cmd_o     <= `JDP_DR_RESET;
			debug_cmd_vld_o <= 1'b0;
		end
		else
		begin
			debug_cmd_vld_o <= 1'b0;
			if (tck_rise)
			begin
				case (st_ff)
					`JDP_ST_CAP_IR:   ir_sh_ff <= `JDP_IR_CAPTURE;
					`JDP_ST_SHIFT_IR: ir_sh_ff <= {tdi_s, ir_sh_ff[`JDP_IR_W-1:1]};
					`JDP_ST_UPD_IR:   ir_ff <= ir_sh_ff;
					`JDP_ST_CAP_DR:
					begin
						dr_sh_ff <= core_data_i;
						byp_ff   <= 1'b0;
					end
					`JDP_ST_SHIFT_DR:
					begin
						dr_sh_ff <= {tdi_s, dr_sh_ff[`JDP_DR_W-1:1]};
						byp_ff   <= tdi_s;
					end
					// commands enter only through the port
					`JDP_ST_UPD_DR:
					begin
						if (ir_ff == `JDP_IR_DEBUG)
						begin
							debug_cmd_o     <= dr_sh_ff;
							debug_cmd_vld_o <= 1'b1;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// output updates on falling test clock edges
	always @(posedge mclk_i)
	begin
		if (tap_rst)
		begin
			tdo_o     <= 1'b0;
			tdo_en_ff <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_en_ff <= (st_ff == `JDP_ST_SHIFT_IR) | (st_ff == `JDP_ST_SHIFT_DR);
			if (st_ff == `JDP_ST_SHIFT_IR)
				tdo_o <= ir_sh_ff[0];
			else if (ir_ff == `JDP_IR_DEBUG)
				tdo_o <= dr_sh_ff[0];
			else
				tdo_o <= byp_ff;
		end
	end

	assign tdo_oe_n_o = ~tdo_en_ff;

	// external request halts the core and enters debug
	always @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			evt_prev_ff  <= 1'b1;
			evt_req_ff   <= 1'b0;
			debug_req_o  <= 1'b0;
			save_pipe_o  <= 1'b0;
			debug_mode_o <= 1'b0;
			ack_cnt_ff   <= 2'h0;
		end
		else
		begin
			evt_prev_ff <= evt_s;
			save_pipe_o <= 1'b0;
			if (ack_cnt_ff != 2'h0)
				ack_cnt_ff <= ack_cnt_ff - 2'h1;
			if (debug_mode_o)
			begin
				if (debug_exit_i)
					debug_mode_o <= 1'b0;
			end
			else if (breakpoint_i | (evt_req_ff & instr_done_i))
			begin
				save_pipe_o  <= 1'b1;
				debug_mode_o <= 1'b1;
				evt_req_ff   <= 1'b0;
				debug_req_o  <= 1'b0;
				ack_cnt_ff   <= `JDP_ACK_CYCLES;
			end
			// Own acknowledge pull is not taken as a new request unless the core leaves debug within four cycles of entry
			else if (evt_prev_ff & ~evt_s & (ack_cnt_ff == 2'h0))
			begin
				evt_req_ff  <= 1'b1;
				debug_req_o <= 1'b1;
			end
		end
	end

	assign debug_event_pin_o      = 1'b0;
	assign debug_event_pin_oe_n_o = sys_rst_i | (ack_cnt_ff == 2'h0);
endmodule // jdp_tap
`default_nettype wire

// ===== logic/jdp_defs.vh
// Shared constants for the test access port and debug event block.
// Assumes inclusion by bare name from design files under logic/.
`ifndef JDP_DEFS_VH
`define JDP_DEFS_VH

// Test controller state codes
`define JDP_ST_RESET      4'h0
`define JDP_ST_IDLE       4'h1
`define JDP_ST_SEL_DR     4'h2
`define JDP_ST_CAP_DR     4'h3
`define JDP_ST_SHIFT_DR   4'h4
`define JDP_ST_EXIT1_DR   4'h5
`define JDP_ST_PAUSE_DR   4'h6
`define JDP_ST_EXIT2_DR   4'h7
`define JDP_ST_UPD_DR     4'h8
`define JDP_ST_SEL_IR     4'h9
`define JDP_ST_CAP_IR     4'ha
`define JDP_ST_SHIFT_IR   4'hb
`define JDP_ST_EXIT1_IR   4'hc
`define JDP_ST_PAUSE_IR   4'hd
`define JDP_ST_EXIT2_IR   4'he
`define JDP_ST_UPD_IR     4'hf

// Instruction register
`define JDP_IR_W          4
`define JDP_IR_RESET      4'h1
`define JDP_IR_CAPTURE    4'h1
`define JDP_IR_DEBUG      4'h2
`define JDP_IR_BYPASS     4'hf

// Debug data register
`define JDP_DR_W          8
`define JDP_DR_RESET      8'h00

// Debug event acknowledge length in clock cycles
`define JDP_ACK_CYCLES    2'h3

`endif

// ===== logic/jdp_sync.v
// Three-stage input synchroniser with agreement filter.
// Assumes a single clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module jdp_sync #(
	parameter RST_VAL = 1'b1
) (
	input  wire clk_i,   // Clock
	input  wire rst_i,   // Sync reset
	input  wire din_i,   // Asynchronous input
	output reg  dout_o   // Filtered level
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	// Stage chain; output changes when stages two and three agree
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_ff  <= RST_VAL;
			s2_ff  <= RST_VAL;
			s3_ff  <= RST_VAL;
			dout_o <= RST_VAL;
		end
		else
		begin
			s1_ff <= din_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				dout_o <= s3_ff;
		end
	end
endmodule // jdp_sync
`default_nettype wire

// ===== sim/jdp_props.sv
// Checker for jdp_tap: event pin and test output enable.
// Assumes sync active high reset on mclk_i.
`timescale 1ns/1ps
`default_nettype none
module jdp_props (
	input wire logic mclk_i,                 // Clock
	input wire logic sys_rst_i,              // Reset
	input wire logic trst_n_i,               // Test reset
	input wire logic tck_i,                  // Test clock
	input wire logic tdo_o,                  // Test out
	input wire logic tdo_oe_n_o,             // Out enable
	input wire logic debug_event_pin_o,      // Pin value
	input wire logic debug_event_pin_oe_n_o, // Pin pull
	input wire logic instr_done_i,           // Instr done
	input wire logic breakpoint_i,           // Breakpoint
	input wire logic debug_exit_i,           // Exit debug
	input wire logic debug_req_o,            // Halt request
	input wire logic save_pipe_o,            // Save pulse
	input wire logic debug_mode_o            // Debug mode
);
	// One clock domain
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (sys_rst_i);
	rst_release_a: assert property (disable iff (1'b0) sys_rst_i |-> debug_event_pin_oe_n_o)
		else $error("pin pulled in reset");
	open_drain_a: assert property (!debug_event_pin_oe_n_o |-> !debug_event_pin_o)
		else $error("pin driven high");
	ack_three_a: assert property ($rose(debug_mode_o) |-> !debug_event_pin_oe_n_o [*3] ##1 debug_event_pin_oe_n_o)
		else $error("ack length");
	ack_cause_a: assert property ($fell(debug_event_pin_oe_n_o) |-> $rose(debug_mode_o))
		else $error("ack without entry");
	entry_cause_a: assert property ($rose(debug_mode_o) |-> $past(breakpoint_i) || $past(instr_done_i && debug_req_o))
		else $error("entry without cause");
	save_pulse_a: assert property (save_pipe_o |-> debug_mode_o ##1 !save_pipe_o)
		else $error("save pulse");
	mode_hold_a: assert property (debug_mode_o && !debug_exit_i |=> debug_mode_o)
		else $error("debug mode lost");
	trst_float_a: assert property (!trst_n_i [*8] |-> tdo_oe_n_o)
		else $error("out driven in test reset");
	tdo_edge_a: assert property ($changed(tdo_o) && $past(trst_n_i, 5) |-> $past(tck_i, 6) && !$past(tck_i, 5))
		else $error("test out moved off falling edge");
endmodule // jdp_props
bind jdp_tap jdp_props u_props (.mclk_i, .sys_rst_i, .trst_n_i, .tdo_oe_n_o, .debug_event_pin_o,
	.debug_event_pin_oe_n_o, .instr_done_i, .breakpoint_i, .debug_exit_i, .debug_req_o, .save_pipe_o, .debug_mode_o,
	.tck_i, .tdo_o);
`default_nettype wire

// ===== sim/jdp_ctl_model.sv
// Outside test controller model for jdp_tap.
// Assumes the bench adds the event pin pull-up.
`timescale 1ns/1ps
`default_nettype none
module jdp_ctl_model (
	output var  logic tck_o,    // Test clock
	output var  logic tms_o,    // Mode select
	output var  logic tdi_o,    // Test data
	output var  logic trst_n_o, // Test reset
	output var  logic evt_n_o,  // Event pull
	input  wire logic tdo_i,    // Test out
	input  wire logic oe_n_i    // Out enable
);
	// Pins idle, clock still between frames
	initial {tck_o, tms_o, tdi_o, trst_n_o, evt_n_o} = 5'h0f;
	task step(input logic m, d, output logic q);
		tms_o = m;
		tdi_o = d;
		#16 tck_o = 1;
		#15 q = oe_n_i ? 1'bz : tdo_i;
		#1 tck_o = 0;
	endtask
	task trst;
		#1 trst_n_o = 0;
		#40 trst_n_o = 1;
	endtask
	// Debug request on event pin
	task evt_pulse;
		#1 evt_n_o = 0;
		#40 evt_n_o = 1;
	endtask
endmodule // jdp_ctl_model
`default_nettype wire

// ===== sim/jdp_tap_test.sv
// Bench for jdp_tap: scan path, test reset, debug entry.
// Assumes jdp_ctl_model drives the test pins.
`timescale 1ns/1ps
`default_nettype none
module jdp_tap_test;
	logic       mclk_i = 0;
	logic       sys_rst_i = 1;
	logic       instr_done_i = 0;
	logic       breakpoint_i = 0;
	logic       debug_exit_i = 0;
	logic [7:0] core_data_i = 8'ha5;
	logic [7:0] q, cmd_seen, ack_cnt = 8'h00, save_cnt = 8'h00;
	wire        tck, tms, tdi, trst_n, evt_n, evt_pin, tdo, tdo_oe_n, evt_o, evt_oe_n, req, save, mode, vld;
	wire  [7:0] cmd;
	int         bad_count = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	// Clock
	initial forever #2 mclk_i = ~mclk_i;
	assign evt_pin = evt_n & (evt_oe_n | evt_o);
	jdp_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n), .evt_n_o(evt_n), .tdo_i(tdo),
		.oe_n_i(tdo_oe_n));
	jdp_tap uut (.mclk_i, .sys_rst_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
		.tdo_oe_n_o(tdo_oe_n), .debug_event_pin_i(evt_pin), .debug_event_pin_o(evt_o), .debug_event_pin_oe_n_o(evt_oe_n),
		.instr_done_i, .breakpoint_i, .debug_exit_i, .core_data_i, .debug_req_o(req), .save_pipe_o(save),
		.debug_mode_o(mode), .debug_cmd_o(cmd), .debug_cmd_vld_o(vld));
	// Ack length, command capture, timeout
	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (!evt_oe_n)
			ack_cnt <= ack_cnt + 8'h01;
		if (save)
			save_cnt <= save_cnt + 8'h01;
		if (vld)
			cmd_seen <= cmd;
		if (cyc == 4000)
		begin
			bad_count++;
			final_report;
		end
	end
	// Compare one value
	task chk(input logic [7:0] got, exp);
		cmp_count++;
		if (got !== exp)
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		if (got !== exp)
			bad_count++;
	endtask
	// Clock n bits, LSB first, off the mclk phase
	task walk(input logic [7:0] m, d, input int n);
		@(negedge mclk_i);
		for (int i = 0; i < n; i++)
			ctl.step(m[i], d[i], q[i]);
	endtask
	// Instruction capture, data capture and command
	task t_scan;
		walk(8'h06, 8'h00, 5);
		walk(8'h08, 8'h02, 4);
		chk(q & 8'h0f, 8'h01);
		walk(8'h03, 8'h00, 4);
		walk(8'h80, 8'h3c, 8);
		chk(q, 8'ha5);
		walk(8'h01, 8'h00, 2);
		repeat (8) @(posedge mclk_i);
		chk(cmd_seen, 8'h3c);
		chk({7'h0, tdo_oe_n}, 8'h01);
		$display("scan done");
	endtask
	// Test reset in mid shift, no test clock, then bypass path
	task t_trst;
		walk(8'h01, 8'h00, 3);
		repeat (8) @(posedge mclk_i);
		chk({7'h0, tdo_oe_n}, 8'h00);
		ctl.trst;
		chk({7'h0, tdo_oe_n}, 8'h01);
		walk(8'h02, 8'h00, 4);
		walk(8'h80, 8'h5a, 8);
		chk(q, 8'hb4);
		walk(8'h01, 8'h00, 2);
		repeat (8) @(posedge mclk_i);
		chk(cmd_seen, 8'h3c);
		$display("trst done");
	endtask
	// External request, repeat ignored, then breakpoint
	task t_debug;
		ctl.evt_pulse;
		chk({7'h0, req}, 8'h01);
		@(posedge mclk_i) instr_done_i <= 1;
		@(posedge mclk_i) instr_done_i <= 0;
		repeat (6) @(posedge mclk_i);
		chk({5'h0, req, mode, save}, 8'h02);
		chk(save_cnt, 8'h01);
		chk(ack_cnt, 8'h03);
		ctl.evt_pulse;
		chk(ack_cnt, 8'h03);
		chk({7'h0, req}, 8'h00);
		@(posedge mclk_i) debug_exit_i <= 1;
		@(posedge mclk_i) debug_exit_i <= 0;
		@(posedge mclk_i) breakpoint_i <= 1;
		chk({7'h0, mode}, 8'h00);
		@(posedge mclk_i) breakpoint_i <= 0;
		repeat (6) @(posedge mclk_i);
		chk(ack_cnt, 8'h06);
		chk(save_cnt, 8'h02);
		$display("debug done");
	endtask
	// Verdict
	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (4) @(posedge mclk_i);
		sys_rst_i <= 0;
		repeat (6) @(posedge mclk_i);
		ctl.trst;
		t_scan;
		t_trst;
		t_debug;
		final_report;
	end
endmodule // jdp_tap_test
`default_nettype wire
